// ===== inc/crc_pkg.sv
// constants shared by the clock and reset control block
package crc_pkg;
   // time base figures
   localparam int CLK_HZ = 25000000;
   localparam int SLOW_RC_HZ = 41000;
   localparam int SLOW_RC_DIV = CLK_HZ / SLOW_RC_HZ;
   localparam int WATCHDOG_MAX_MS = 400;
   localparam int WATCHDOG_MAX_TICKS = WATCHDOG_MAX_MS * SLOW_RC_HZ / 1000;
   localparam int PIN_MIN_TICKS = 2;
   localparam int DIV_APPLY_CYCLES = 16;
   // register indices, byte address is four times the index
   localparam logic [13:0] IDX_TIMING = 14'h0094;
   localparam logic [13:0] IDX_SOFT_CMD = 14'h0097;
   localparam logic [13:0] IDX_CLOCK = 14'h00D8;
   localparam logic [13:0] IDX_VRESET = 14'h00E3;
   localparam logic [13:0] IDX_VDETECT = 14'h00E4;
   localparam logic [13:0] IDX_TRIM = 14'h00F6;
   localparam logic [13:0] IDX_MISC_B = 14'h00F7;
   localparam logic [13:0] IDX_STROBE = 14'h00F8;
   localparam logic [13:0] IDX_CFG_LOW = 14'h3FFD;
   localparam logic [13:0] IDX_CFG_HIGH = 14'h3FFF;
   // reset values, masks and the soft reset key
   localparam logic [7:0] RST_TIMING = 8'h00;
   localparam logic [7:0] RST_CLOCK = 8'h23;
   localparam logic [7:0] RST_VRESET = 8'h00;
   localparam logic [7:0] RST_VDETECT = 8'h00;
   localparam logic [7:0] RST_MISC_B = 8'h06;
   localparam logic [7:0] RST_STROBE = 8'h0C;
   localparam logic [7:0] VRESET_MASK = 8'h3F;
   localparam logic [7:0] TRIM_MASK = 8'h7F;
   localparam logic [7:0] SOFT_RESET_KEY = 8'h56;
   // clock control bits
   localparam int CK_SLOW_TYPE = 7;
   localparam int CK_FAST_TYPE = 6;
   localparam int CK_SLOW_STOP = 5;
   localparam int CK_PERIPH_STOP = 4;
   localparam int CK_FAST_STOP = 3;
   localparam int CK_FAST_SEL = 2;
   localparam int CK_DIV_HI = 1;
   // watchdog and reset fields
   localparam int WD_CTL_HI = 7;
   localparam int WD_CTL_LO = 6;
   localparam int PWR_SAVE = 5;
   localparam int WD_PER_HI = 5;
   localparam int WD_PER_LO = 4;
   localparam int WD_CLEAR = 7;
   localparam int PON_OFF = 5;
   localparam int VR_OFF = 4;
   localparam int LEVEL_HI = 3;
   localparam int VD_POL = 7;
   localparam int VD_OUT = 6;
   localparam int VD_HYST = 5;
   localparam int VD_OFF = 4;
   localparam int CFG_PIN_EN = 6;
   localparam int TRIM_HI = 6;
   localparam logic [1:0] WD_ALWAYS = 2'h3;
   localparam logic [1:0] WD_RUN_ONLY = 2'h2;
endpackage

// ===== logic/watchdog_timer.sv
// watchdog counter on the slow rc tick with selectable overflow period
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer #(
   parameter int CW = 15,
   parameter logic [CW-1:0] TOP = 15'h4010
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic tick,
   input wire logic run,
   input wire logic clear,
   input wire logic [1:0] periodSel,
   output logic overflow
);
   logic [CW-1:0] count_q; // elapsed slow ticks
   logic [CW-1:0] limit; // ticks per period

   // each period code halves the interval: 400, 200, 100, 50 ms
   assign limit = TOP >> periodSel;

   // count ticks, clear on request or chip reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_q <= '0;
         overflow <= 1'b0;
      end else begin
         overflow <= 1'b0;
         if (clear) begin
            count_q <= '0;
         end else if (run && tick) begin
            if (count_q >= limit - 1'b1) begin
               count_q <= '0;
               overflow <= 1'b1;
            end else begin
               count_q <= count_q + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== logic/pin_reset_filter.sv
// glitch filter for the active low reset pin
`timescale 1ns/100ps
`default_nettype none
module pin_reset_filter #(
   parameter int MIN_TICKS = 2
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic tick,
   input wire logic pinResetN,
   output logic held
);
   localparam int W = $clog2(MIN_TICKS + 1);
   logic [W-1:0] count_q; // slow ticks seen while low

   // the first tick may cut a period short, so one extra tick is demanded
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_q <= '0;
         held <= 1'b0;
      end else if (pinResetN) begin
         count_q <= '0; // any high level restarts the measurement
         held <= 1'b0;
      end else if (tick && !held) begin
         if (count_q == W'(MIN_TICKS)) begin
            held <= 1'b1;
         end else begin
            count_q <= count_q + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== logic/clock_reset_control.sv
// clock selection, prescaler, trim and reset control behind an apb slave
`timescale 1ns/100ps
`default_nettype none
module clock_reset_control
   import crc_pkg::*;
#(
   parameter int SLOW_DIV = SLOW_RC_DIV,
   parameter int WD_TICKS = WATCHDOG_MAX_TICKS
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata_q,
   output logic pready_q,
   output logic pslverr_q,
   input wire logic cpuIdle,
   input wire logic cpuPowerDown,
   input wire logic lvDetectOutput,
   input wire logic lvResetTrip,
   input wire logic powerOnTrip,
   input wire logic pinResetN,
   input wire logic [7:0] cfgWordLow,
   input wire logic [7:0] cfgWordHigh,
   output logic chipReset_q,
   output logic sysclkFastSel_q,
   output logic fastSrcType_q,
   output logic slowSrcType_q,
   output logic fastOscStop_q,
   output logic slowOscStop_q,
   output logic periphClkGate_q,
   output logic [1:0] sysclkDivider_q,
   output logic [6:0] fastRcTrim_q,
   output logic lvResetEn_q,
   output logic [3:0] lvResetLevel_q,
   output logic powerOnEn_q,
   output logic lvDetectEn_q,
   output logic [3:0] lvDetectLevel_q,
   output logic lvDetectHyst_q,
   output logic lvDetectFlag_q
);
   localparam int DIVW = $clog2(SLOW_DIV);

   logic [13:0] idx; // word index of the access
   logic wrEn; // write accepted at this edge
   logic mapped; // index decodes to a register
   logic [7:0] rdMux; // read data before the flop
   logic [7:0] wByte; // written byte lane 0
   logic [7:0] timing_q; // watchdog period and others
   logic [7:0] clock_q; // clock control
   logic [7:0] clockNext; // clock control after guards
   logic [7:0] vreset_q; // voltage reset control
   logic [7:0] vdetect_q; // voltage detect control, bit 6 unused
   logic [7:0] miscB_q; // watchdog control and power save
   logic [7:0] strobe_q; // watchdog clear and other strobes
   logic [6:0] trim_q; // fast rc trim
   logic [7:0] cfgLow_q; // flash word, caught after reset
   logic [7:0] cfgHigh_q; // flash word, caught after reset
   logic cfgDone_q; // flash words caught
   logic [DIVW-1:0] slowCnt_q; // slow rc tick divider
   logic slowTick; // one cycle per slow rc period
   logic [3:0] applyCnt_q; // prescaler apply interval
   logic asleep; // idle, halt or stop
   logic wdArm; // watchdog may reset the chip
   logic wdOvf; // watchdog overflow pulse
   logic pinHeld; // filtered pin reset level
   logic softHit; // soft reset command written

   // simple decode of the word index and write strobe
   function automatic logic hitW(input logic [13:0] i);
      return wrEn && idx == i;
   endfunction

   assign idx = paddr[15:2];
   assign wByte = pwdata[7:0];
   assign wrEn = psel && penable && pready_q && pwrite && pstrb[0];
   assign asleep = cpuIdle || cpuPowerDown;
   assign softHit = hitW(IDX_SOFT_CMD) && wByte == SOFT_RESET_KEY;
   assign wdArm = miscB_q[WD_CTL_HI:WD_CTL_LO] == WD_ALWAYS ||
      (miscB_q[WD_CTL_HI:WD_CTL_LO] == WD_RUN_ONLY && !asleep);

   // read multiplexer; write-only and reserved bits read zero
   always_comb begin
      mapped = 1'b1;
      rdMux = 8'h00;
      case (idx)
         IDX_TIMING: rdMux = timing_q;
         IDX_SOFT_CMD: rdMux = 8'h00;
         IDX_CLOCK: rdMux = clock_q;
         IDX_VRESET: rdMux = vreset_q & VRESET_MASK;
         IDX_VDETECT: begin
            rdMux = vdetect_q;
            rdMux[VD_OUT] = lvDetectOutput;
         end
         IDX_TRIM: rdMux = {1'b0, trim_q};
         IDX_MISC_B: rdMux = miscB_q;
         IDX_STROBE: rdMux = strobe_q;
         IDX_CFG_LOW: rdMux = cfgLow_q;
         IDX_CFG_HIGH: rdMux = cfgHigh_q;
         default: mapped = 1'b0;
      endcase
   end

   // apb answer: one access cycle, read data and error caught at setup
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel && !penable;
         if (psel && !penable) begin
            prdata_q <= {24'h00_0000, rdMux};
            pslverr_q <= !mapped;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // flash words are caught once after release, never under reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfgDone_q <= 1'b0;
         cfgLow_q <= 8'h00;
         cfgHigh_q <= 8'h00;
      end else if (!cfgDone_q) begin
         cfgDone_q <= 1'b1;
         cfgLow_q <= cfgWordLow;
         cfgHigh_q <= cfgWordHigh;
      end
   end

   // guards on the clock control write; refused bits keep their value
   always_comb begin
      clockNext = wByte;
      if (!clock_q[CK_FAST_SEL]) begin
         clockNext[CK_SLOW_TYPE] = clock_q[CK_SLOW_TYPE];
      end else begin
         clockNext[CK_FAST_TYPE] = clock_q[CK_FAST_TYPE];
         clockNext[CK_FAST_STOP] = clock_q[CK_FAST_STOP];
      end
      if (clock_q[CK_FAST_STOP]) begin
         clockNext[CK_FAST_SEL] = clock_q[CK_FAST_SEL];
      end
   end

   // clock control register; reset selects the slow rc, divide by one
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clock_q <= RST_CLOCK;
      end else if (chipReset_q) begin
         clock_q <= RST_CLOCK;
      end else if (hitW(IDX_CLOCK)) begin
         clock_q <= clockNext;
      end
   end

   // plain read/write registers, restored by every reset source
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         timing_q <= RST_TIMING;
         vreset_q <= RST_VRESET;
         vdetect_q <= RST_VDETECT;
         miscB_q <= RST_MISC_B;
      end else if (chipReset_q) begin
         timing_q <= RST_TIMING;
         vreset_q <= RST_VRESET;
         vdetect_q <= RST_VDETECT;
         miscB_q <= RST_MISC_B;
      end else begin
         if (hitW(IDX_TIMING)) begin
            timing_q <= wByte;
         end
         if (hitW(IDX_VRESET)) begin
            vreset_q <= wByte & VRESET_MASK;
         end
         if (hitW(IDX_VDETECT)) begin
            vdetect_q <= wByte;
         end
         if (hitW(IDX_MISC_B)) begin
            miscB_q <= wByte;
         end
      end
   end

   // strobe register: the clear bit lives one cycle, a new write wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strobe_q <= RST_STROBE;
      end else if (chipReset_q) begin
         strobe_q <= RST_STROBE;
      end else if (hitW(IDX_STROBE)) begin
         strobe_q <= wByte;
      end else begin
         strobe_q[WD_CLEAR] <= 1'b0;
      end
   end

   // trim reloads the factory value from flash after any reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trim_q <= 7'h00;
      end else if (!cfgDone_q) begin
         trim_q <= cfgWordLow[TRIM_HI:0];
      end else if (chipReset_q) begin
         trim_q <= cfgLow_q[TRIM_HI:0];
      end else if (hitW(IDX_TRIM)) begin
         trim_q <= wByte[TRIM_HI:0];
      end
   end

   // slow rc time base as an enable pulse from the single clock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         slowCnt_q <= '0;
      end else if (slowCnt_q == DIVW'(SLOW_DIV - 1)) begin
         slowCnt_q <= '0;
      end else begin
         slowCnt_q <= slowCnt_q + 1'b1;
      end
   end
   assign slowTick = slowCnt_q == DIVW'(SLOW_DIV - 1);

   watchdog_timer #(
      .CW($clog2(WD_TICKS + 1)),
      .TOP(($clog2(WD_TICKS + 1))'(WD_TICKS))
   ) u_watchdog (
      .clk(clk),
      .rstn(rstn),
      .tick(slowTick),
      .run(wdArm),
      .clear(strobe_q[WD_CLEAR] || chipReset_q),
      .periodSel(timing_q[WD_PER_HI:WD_PER_LO]),
      .overflow(wdOvf)
   );

   pin_reset_filter #(
      .MIN_TICKS(PIN_MIN_TICKS)
   ) u_pin_filter (
      .clk(clk),
      .rstn(rstn),
      .tick(slowTick),
      .pinResetN(pinResetN),
      .held(pinHeld)
   );

   // chip reset: any enabled source; pin and trip levels hold it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         chipReset_q <= 1'b0;
      end else begin
         chipReset_q <= softHit
            || (wdOvf && wdArm)
            || (lvResetTrip && lvResetEn_q)
            || (powerOnTrip && powerOnEn_q)
            || (pinHeld && cfgHigh_q[CFG_PIN_EN]);
      end
   end

   // prescaler setting is taken at the end of each 16 cycle interval
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         applyCnt_q <= 4'h0;
         sysclkDivider_q <= RST_CLOCK[CK_DIV_HI:0];
      end else begin
         applyCnt_q <= applyCnt_q + 1'b1;
         if (applyCnt_q == 4'(DIV_APPLY_CYCLES - 1)) begin
            sysclkDivider_q <= clock_q[CK_DIV_HI:0];
         end
      end
   end

   // registered control outputs toward oscillators and analog blocks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sysclkFastSel_q <= 1'b0;
         fastSrcType_q <= 1'b0;
         slowSrcType_q <= 1'b0;
         fastOscStop_q <= 1'b0;
         slowOscStop_q <= 1'b0;
         periphClkGate_q <= 1'b0;
         fastRcTrim_q <= 7'h00;
         lvResetEn_q <= 1'b0;
         lvResetLevel_q <= 4'h0;
         powerOnEn_q <= 1'b1;
         lvDetectEn_q <= 1'b0;
         lvDetectLevel_q <= 4'h0;
         lvDetectHyst_q <= 1'b0;
         lvDetectFlag_q <= 1'b0;
      end else begin
         sysclkFastSel_q <= clock_q[CK_FAST_SEL];
         fastSrcType_q <= clock_q[CK_FAST_TYPE];
         slowSrcType_q <= clock_q[CK_SLOW_TYPE];
         // the fast oscillator only stops while the slow clock runs the chip
         fastOscStop_q <= clock_q[CK_FAST_STOP] && !clock_q[CK_FAST_SEL];
         slowOscStop_q <= clock_q[CK_SLOW_STOP] && cpuPowerDown;
         periphClkGate_q <= clock_q[CK_PERIPH_STOP] && cpuIdle;
         fastRcTrim_q <= trim_q;
         lvResetEn_q <= !vreset_q[VR_OFF] && !(miscB_q[PWR_SAVE] && asleep);
         lvResetLevel_q <= vreset_q[LEVEL_HI:0];
         powerOnEn_q <= !vreset_q[PON_OFF];
         lvDetectEn_q <= !vdetect_q[VD_OFF] && !asleep;
         lvDetectLevel_q <= vdetect_q[LEVEL_HI:0];
         lvDetectHyst_q <= vdetect_q[VD_HYST];
         lvDetectFlag_q <= !vdetect_q[VD_OFF] && !asleep &&
            (lvDetectOutput ^ vdetect_q[VD_POL]);
      end
   end

   // checks on the block's own registers and outputs
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   soft_reset_a: assert property (softHit |=> chipReset_q ##1 clock_q == RST_CLOCK)
      else $error("soft reset command did not reset the chip");
   soft_key_a: assert property (wrEn && idx == IDX_SOFT_CMD && wByte != SOFT_RESET_KEY && !wdOvf && !lvResetTrip
      && !powerOnTrip && !pinHeld |=> !chipReset_q)
      else $error("wrong soft command value caused a reset");
   wd_clear_a: assert property ($rose(strobe_q[WD_CLEAR]) |=> !strobe_q[WD_CLEAR] || $past(wrEn))
      else $error("watchdog clear bit did not self clear");
   lv_save_a: assert property (miscB_q[PWR_SAVE] && asleep |=> !lvResetEn_q)
      else $error("voltage reset stayed on while asleep with power save");
   lv_level_a: assert property (##1 lvResetLevel_q == $past(vreset_q[LEVEL_HI:0]))
      else $error("voltage reset level not forwarded");
   pon_off_a: assert property (##1 powerOnEn_q == !$past(vreset_q[PON_OFF]))
      else $error("power-on reset enable wrong");
   detect_flag_a: assert property (!vdetect_q[VD_OFF] && !asleep && lvDetectOutput && !vdetect_q[VD_POL]
      |=> lvDetectFlag_q)
      else $error("detect flag not raised for low supply");
   detect_off_a: assert property (asleep || vdetect_q[VD_OFF] |=> !lvDetectEn_q && !lvDetectFlag_q)
      else $error("detect active while disabled or asleep");
   div_apply_a: assert property ($changed(clock_q[CK_DIV_HI:0]) ##1 $stable(clock_q[CK_DIV_HI:0]) [*8]
      ##1 $stable(clock_q[CK_DIV_HI:0]) [*8] |-> sysclkDivider_q == clock_q[CK_DIV_HI:0])
      else $error("prescaler setting not applied in 16 cycles");
   slow_type_a: assert property (!$past(chipReset_q) && $changed(clock_q[CK_SLOW_TYPE])
      |-> $past(clock_q[CK_FAST_SEL]))
      else $error("slow type changed outside fast mode");
   fast_type_a: assert property (!$past(chipReset_q) && $changed(clock_q[CK_FAST_TYPE])
      |-> !$past(clock_q[CK_FAST_SEL]))
      else $error("fast type changed outside slow mode");
   sel_guard_a: assert property (!$past(chipReset_q) && $changed(clock_q[CK_FAST_SEL])
      |-> !$past(clock_q[CK_FAST_STOP]))
      else $error("clock select changed with fast clock stopped");

   soft_reset_c: cover property (softHit ##1 chipReset_q);
   go_fast_c: cover property ($rose(sysclkFastSel_q));
   wd_reset_c: cover property (wdOvf && wdArm);
   pin_reset_c: cover property (pinHeld && cfgHigh_q[CFG_PIN_EN] ##1 chipReset_q);
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the clock and reset control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import crc_pkg::*;
   localparam int SIM_DIV = 4; // short slow tick keeps watchdog runs brief
   localparam int SIM_WD = 64; // watchdog ticks at the longest period
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q, chipReset_q, sysclkFastSel_q, fastOscStop_q, slowOscStop_q, periphClkGate_q;
   logic cpuIdle = 1'b0, cpuPowerDown = 1'b0, lvDetectOutput = 1'b0, pinResetN = 1'b1;
   logic lvResetTrip = 1'b0, powerOnTrip = 1'b0; // supply and power-on detector levels
   logic fastSrcType_q, slowSrcType_q;
   logic [7:0] cfgWordLow = 8'h35, cfgWordHigh = 8'h40; // pin reset enabled at first
   logic [1:0] sysclkDivider_q;
   logic [6:0] fastRcTrim_q;
   logic lvResetEn_q, powerOnEn_q, lvDetectEn_q, lvDetectHyst_q, lvDetectFlag_q;
   logic [3:0] lvResetLevel_q, lvDetectLevel_q;
   logic [7:0] rd; // last read byte
   logic err; // last error response
   int n_mismatch = 0, tests_run = 0, c;
   clock_reset_control #(.SLOW_DIV(SIM_DIV), .WD_TICKS(SIM_WD)) u_clock_reset_control (.clk(clk), .rstn(rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .cpuIdle(cpuIdle),
      .cpuPowerDown(cpuPowerDown), .lvDetectOutput(lvDetectOutput), .lvResetTrip(lvResetTrip),
      .powerOnTrip(powerOnTrip),
      .pinResetN(pinResetN), .cfgWordLow(cfgWordLow), .cfgWordHigh(cfgWordHigh), .chipReset_q(chipReset_q),
      .sysclkFastSel_q(sysclkFastSel_q), .fastSrcType_q(fastSrcType_q), .slowSrcType_q(slowSrcType_q),
      .fastOscStop_q(fastOscStop_q),
      .slowOscStop_q(slowOscStop_q), .periphClkGate_q(periphClkGate_q), .sysclkDivider_q(sysclkDivider_q),
      .fastRcTrim_q(fastRcTrim_q), .lvResetEn_q(lvResetEn_q), .lvResetLevel_q(lvResetLevel_q),
      .powerOnEn_q(powerOnEn_q), .lvDetectEn_q(lvDetectEn_q), .lvDetectLevel_q(lvDetectLevel_q),
      .lvDetectHyst_q(lvDetectHyst_q), .lvDetectFlag_q(lvDetectFlag_q));
   // 25 MHz clock
   always #20 clk = ~clk;
   // verdict and end of run, the only exit
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // single comparison point
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic [13:0] idx, input logic wr, input logic [7:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready_q !== 1'b1 && n < 8);
      rd = prdata_q[7:0];
      err = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready_q !== 1'b1) begin
         n_mismatch++; // a slave that never answers ends the run
         report_and_stop();
      end
   endtask
   // counts cycles until a chip reset request, c equals bound when none came
   task automatic waitRst(input int bound);
      c = 0;
      while (chipReset_q !== 1'b1 && c < bound) begin
         @(posedge clk);
         c++;
      end
   endtask
   // reset values, unmapped access and trim load
   task automatic t_defaults();
      apb(IDX_CLOCK, 1'b0, 8'h00);
      check(rd, RST_CLOCK);
      check(sysclkDivider_q, 2'b11);
      check(sysclkFastSel_q, 1'b0);
      apb(IDX_MISC_B, 1'b0, 8'h00);
      check(rd, RST_MISC_B);
      apb(IDX_STROBE, 1'b0, 8'h00);
      check(rd, RST_STROBE);
      apb(14'h0010, 1'b0, 8'h00);
      check({err, rd}, 9'h100);
      check(fastRcTrim_q, 7'h35);
      apb(IDX_TRIM, 1'b1, 8'h7F);
      cyc(2);
      check(fastRcTrim_q, 7'h7F);
   endtask
   // guarded clock bits, one write after another, then prescaler codes
   task automatic t_clock();
      // no written value has both fast stop and fast select high
      logic [7:0] wv [8] = '{8'hA3, 8'h63, 8'h67, 8'hE7, 8'hA7, 8'hEB, 8'hEB, 8'hE7};
      logic [7:0] ev [8] = '{8'h23, 8'h63, 8'h67, 8'hE7, 8'hE7, 8'hE3, 8'hEB, 8'hE3};
      for (int i = 0; i < 8; i++) begin
         if (i == 2) begin
            cyc(CLK_HZ / 500); // crystal settles 2 ms before the fast select
         end
         apb(IDX_CLOCK, 1'b1, wv[i]);
         apb(IDX_CLOCK, 1'b0, 8'h00);
         check(rd, ev[i]);
         check(sysclkFastSel_q, ev[i][CK_FAST_SEL]);
      end
      for (int k = 0; k < 4; k++) begin
         apb(IDX_CLOCK, 1'b1, {6'b111010, k[1:0]});
         c = 0;
         while (sysclkDivider_q !== k[1:0] && c < 20) begin
            @(posedge clk);
            c++;
         end
         check(c <= 17, 1'b1);
      end
      check(fastOscStop_q, 1'b1);
      check({slowSrcType_q, fastSrcType_q}, 2'b11);
      apb(IDX_CLOCK, 1'b1, 8'hFB);
      cpuIdle <= 1'b1;
      cpuPowerDown <= 1'b1;
      cyc(3);
      check({periphClkGate_q, slowOscStop_q}, 2'b11);
      cpuIdle <= 1'b0;
      cpuPowerDown <= 1'b0;
   endtask
   // soft command: wrong key ignored, key resets registers
   task automatic t_soft();
      apb(IDX_SOFT_CMD, 1'b1, 8'h55);
      waitRst(6);
      check(c, 6);
      apb(IDX_SOFT_CMD, 1'b1, SOFT_RESET_KEY);
      waitRst(6);
      check(c < 6, 1'b1);
      cyc(3);
      apb(IDX_CLOCK, 1'b0, 8'h00);
      check(rd, RST_CLOCK);
   endtask
   // watchdog periods, run-only arming, clearing
   task automatic t_watchdog();
      int e;
      for (int p = 3; p >= 2; p--) begin
         e = (SIM_WD >> p) * SIM_DIV;
         apb(IDX_TIMING, 1'b1, {2'b00, p[1:0], 4'h0});
         apb(IDX_MISC_B, 1'b1, 8'hC6);
         waitRst(300);
         check(c >= e - 8 && c <= e + 8, 1'b1);
         cyc(3);
      end
      cpuIdle <= 1'b1;
      apb(IDX_TIMING, 1'b1, 8'h30);
      apb(IDX_MISC_B, 1'b1, 8'h86);
      waitRst(100);
      check(c, 100);
      cpuIdle <= 1'b0;
      waitRst(60);
      check(c < 60, 1'b1);
      cyc(3);
      apb(IDX_TIMING, 1'b1, 8'h30);
      apb(IDX_MISC_B, 1'b1, 8'hC6);
      repeat (10) begin
         apb(IDX_STROBE, 1'b1, 8'h80);
         waitRst(2);
         check(c, 2);
      end
      apb(IDX_STROBE, 1'b0, 8'h00);
      check(rd[7], 1'b0);
      waitRst(60);
      check(c < 60, 1'b1);
      cyc(3);
   endtask
   // detect flag polarity, live output, sleep disable, hysteresis and level
   task automatic t_lvd();
      lvDetectOutput <= 1'b1;
      apb(IDX_VDETECT, 1'b1, 8'h2A);
      cyc(3);
      check({lvDetectFlag_q, lvDetectHyst_q, lvDetectLevel_q}, 6'h3A);
      apb(IDX_VDETECT, 1'b1, 8'hAA);
      apb(IDX_VDETECT, 1'b0, 8'h00);
      check(rd, 8'hEA);
      check(lvDetectFlag_q, 1'b0);
      lvDetectOutput <= 1'b0;
      cyc(3);
      check(lvDetectFlag_q, 1'b1);
      cpuIdle <= 1'b1;
      cyc(3);
      check({lvDetectFlag_q, lvDetectEn_q}, 2'b00);
      cpuIdle <= 1'b0;
      apb(IDX_VDETECT, 1'b1, 8'hBA);
      cyc(3);
      check({lvDetectFlag_q, lvDetectEn_q}, 2'b00);
   endtask
   // voltage and power-on reset enables, level, power save in sleep
   task automatic t_lvr();
      apb(IDX_VRESET, 1'b1, 8'h15);
      cyc(2);
      check({lvResetEn_q, powerOnEn_q, lvResetLevel_q}, 6'h15);
      apb(IDX_VRESET, 1'b1, 8'h27);
      cyc(2);
      check({lvResetEn_q, powerOnEn_q, lvResetLevel_q}, 6'h27);
      apb(IDX_MISC_B, 1'b1, 8'h26);
      cpuPowerDown <= 1'b1;
      cyc(3);
      check(lvResetEn_q, 1'b0);
      apb(IDX_MISC_B, 1'b1, 8'h06);
      cyc(3);
      check(lvResetEn_q, 1'b1);
      cpuPowerDown <= 1'b0;
      // power-on source is switched off here, the voltage source is on
      powerOnTrip <= 1'b1;
      waitRst(6);
      check(c, 6);
      powerOnTrip <= 1'b0;
      lvResetTrip <= 1'b1;
      waitRst(6);
      check(c < 6, 1'b1);
      lvResetTrip <= 1'b0;
      cyc(3);
   endtask
   // pin filter and the configuration gate, second reset mid-run
   task automatic t_pin();
      pinResetN <= 1'b0;
      cyc(2);
      pinResetN <= 1'b1;
      waitRst(12);
      check(c, 12);
      pinResetN <= 1'b0;
      waitRst(30);
      check(c < 30, 1'b1);
      pinResetN <= 1'b1;
      cyc(6);
      rstn <= 1'b0;
      cfgWordHigh <= 8'h00; // words are caught only after a hard reset
      cyc(6);
      rstn <= 1'b1;
      cyc(2);
      pinResetN <= 1'b0;
      waitRst(30);
      check(c, 30);
      pinResetN <= 1'b1;
   endtask
   // main sequence
   initial begin
      cyc(6);
      rstn <= 1'b1;
      cyc(2);
      t_defaults();
      t_clock();
      t_soft();
      t_watchdog();
      t_lvd();
      t_lvr();
      t_pin();
      report_and_stop();
   end
endmodule
`default_nettype wire
